// ---- src/lpmc_pkg.sv ----
// package: register map, field positions, reset values and states of the low power controller
package lpmc_pkg;

    // ********************************************************
    // register byte addresses (one aligned word each)
    // ********************************************************
    localparam logic [7:0] ADR_SYS_FIRST = 8'h00;
    localparam logic [7:0] ADR_SYS_SECOND = 8'h04;
    localparam logic [7:0] ADR_WARMUP = 8'h08;
    localparam logic [7:0] ADR_INT_EN = 8'h0C;
    localparam logic [7:0] ADR_INT_LATCH = 8'h10;
    localparam logic [7:0] ADR_TBT_CTRL = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int FIRST_STOP_BIT = 7;
    localparam int FIRST_RELM_BIT = 6;
    localparam int SECOND_XTEN_BIT = 5;
    localparam int SECOND_SYSCK_BIT = 4;
    localparam int SECOND_IDLE_BIT = 3;
    localparam int SECOND_TIMING_GEN_HALT_REQUEST_BIT = 2;
    localparam int TBT_EN_BIT = 7;
    localparam int TBT_LATCH_IDX = 5;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [7:0] SYS_FIRST_RST = 8'h00;
    localparam logic [7:0] SYS_SECOND_RST = 8'h00;
    localparam logic [15:0] WARMUP_RST = 16'h00FF;
    localparam logic [7:0] TBT_CTRL_RST = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ********************************************************
    // states and run modes
    // ********************************************************
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_STOP = 3'b001,
        ST_WARMUP = 3'b010,
        ST_IDLE = 3'b011,
        ST_TB_HALT = 3'b100
    } lpmc_state_t;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_DUAL = 2'b01,
        MODE_SLOW = 2'b10
    } lpmc_mode_t;

endpackage

// ---- src/lpmc_top.sv ----
// low power mode controller: stop release, cpu-halt and time-base-only halt sequencing
//
// Functional notes
// RULE_01: stop release: oscillators, halted warm-up, resume
// RULE_02: warm-up length set by warm-up counter
// RULE_03: clear prescaler and divider on resume
// RULE_04: from single-clock run: high oscillator only
// RULE_05: from dual-clock run: both oscillators restart
// RULE_06: from slow run: low oscillator only
// RULE_07: dual-clock return: high clock feeds counter
// RULE_08: cpu-halt: cpu and watchdog stop, peripherals run
// RULE_09: cpu-halt keeps memory, registers, port latches
// RULE_10: cpu-halt holds pc two instructions ahead
// RULE_11: software prepares enables before cpu-halt request
// RULE_12: halt-request bit write enters cpu-halt
// RULE_13: pending release at request: no halt
// RULE_14: watchdog interrupt at request: no halt
// RULE_15: release clears halt bit, restores mode
// RULE_16: reset ends halt, warm-up, single-clock run
// RULE_17: master enable clear: resume without vectoring
// RULE_18: software clears wake latch by loads
// RULE_19: master enable set: service, then resume
// RULE_20: time-base halt gates all but time base
// RULE_21: time-base halt keeps memory, registers, latches
// RULE_22: time-base halt holds pc two ahead
// RULE_23: stop bit write enters full stop
// RULE_24: timing-generator halt bit enters time-base halt
// RULE_25: time base source falling edge releases
`timescale 1ns/1ps
module lpmc_top #(
    parameter int NUM_INT = 8,
    parameter int WUC_DIV = 16,
    parameter int PC_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // cpu and interrupt side
    input wire logic imf_i,
    input wire logic wdt_int_i,
    input wire logic [NUM_INT-1:0] int_req_i,
    input wire logic [PC_W-1:0] next_pc_i,
    // pins and time base source
    input wire logic stop_release_i,
    input wire logic tbt_src_clk_i,
    // control outputs
    output logic cpu_halt_o,
    output logic wdt_halt_o,
    output logic periph_clk_en_o,
    output logic tbt_clk_en_o,
    output logic retain_o,
    output logic hf_osc_en_o,
    output logic lf_osc_en_o,
    output logic wuc_src_hf_o,
    output logic prescaler_clr_o,
    output logic resume_o,
    output logic vector_req_o,
    output logic [PC_W-1:0] pc_hold_o,
    output logic [NUM_INT-1:0] interrupt_latch_o
);
    import lpmc_pkg::*;

    // ********************************************************
    // registers and state
    // ********************************************************
    lpmc_state_t state;
    lpmc_state_t next_state;
    lpmc_mode_t stop_mode;
    logic [7:0] system_control_first;
    logic [7:0] system_control_second;
    logic [15:0] warmup_load;
    logic [15:0] wuc_cnt;
    logic [15:0] wuc_div;
    logic [NUM_INT-1:0] individual_interrupt_enable;
    logic [NUM_INT-1:0] interrupt_latch;
    logic [7:0] time_base_timer_control;
    logic [2:0] rel_q;
    logic rel_stable;
    logic [2:0] tb_q;
    logic tb_stable;

    // ********************************************************
    // bus decode
    // ********************************************************
    wire bus_req = wb_cyc_i & wb_stb_i;
    // writes land on the edge where the master sees ack
    wire wr_now = bus_req & wb_we_i & wb_ack_o;
    wire sel_first = wb_adr_i == ADR_SYS_FIRST;
    wire sel_second = wb_adr_i == ADR_SYS_SECOND;
    wire sel_warmup = wb_adr_i == ADR_WARMUP;
    wire sel_int_en = wb_adr_i == ADR_INT_EN;
    wire sel_latch = wb_adr_i == ADR_INT_LATCH;
    wire sel_tbt = wb_adr_i == ADR_TBT_CTRL;
    wire sel_status = wb_adr_i == ADR_STATUS;
    wire wr_b0 = wr_now & wb_sel_i[0];
    wire wr_b1 = wr_now & wb_sel_i[1];

    wire [31:0] status_word = {24'h00_0000, 1'b0, stop_mode, 2'b00, state};
    wire [31:0] read_data =
        sel_first ? {24'h00_0000, system_control_first} :
        sel_second ? {24'h00_0000, system_control_second} :
        sel_warmup ? {16'h0000, warmup_load} :
        sel_int_en ? {{(32-NUM_INT){1'b0}}, individual_interrupt_enable} :
        sel_latch ? {{(32-NUM_INT){1'b0}}, interrupt_latch} :
        sel_tbt ? {24'h00_0000, time_base_timer_control} :
        sel_status ? status_word : READ_ZERO;

    // ********************************************************
    // input synchronisers
    // ********************************************************
    // a level counts only once stages two and three agree
    wire rel_agree = rel_q[1] == rel_q[2];
    wire rel_rise = rel_agree & rel_q[2] & ~rel_stable;
    wire tb_agree = tb_q[1] == tb_q[2];
    wire tbt_fall = tb_agree & ~tb_q[2] & tb_stable; // RULE_25

    // ********************************************************
    // request and release conditions
    // ********************************************************
    wire wake_pending = |(interrupt_latch & individual_interrupt_enable);
    wire relm_level = system_control_first[FIRST_RELM_BIT];
    wire stop_req = wr_b0 & sel_first & wb_dat_i[FIRST_STOP_BIT]; // RULE_23
    // level release: stop refused while the release pin already reads high
    wire stop_start = stop_req & ~(relm_level & rel_stable);
    wire idle_req = wr_b0 & sel_second & wb_dat_i[SECOND_IDLE_BIT]; // RULE_12
    wire idle_refused = wake_pending | wdt_int_i; // RULE_13 RULE_14
    wire tg_req = wr_b0 & sel_second & wb_dat_i[SECOND_TIMING_GEN_HALT_REQUEST_BIT]; // RULE_24
    wire stop_release = relm_level ? (rel_agree & rel_q[2]) : rel_rise;
    wire wuc_tick = wuc_div == 16'(WUC_DIV - 1);
    wire wuc_done = wuc_cnt == 16'h0000; // RULE_02
    wire tbt_irq_en = time_base_timer_control[TBT_EN_BIT];
    wire tb_release = (state == ST_TB_HALT) & tbt_fall;
    wire idle_release = (state == ST_IDLE) & wake_pending;

    // ********************************************************
    // mode decode
    // ********************************************************
    wire lpmc_mode_t mode_now =
        system_control_second[SECOND_SYSCK_BIT] ? MODE_SLOW :
        system_control_second[SECOND_XTEN_BIT] ? MODE_DUAL : MODE_SINGLE;
    // oscillators follow the mode held before the stop while warming up
    wire lpmc_mode_t osc_mode = (next_state == ST_WARMUP) ? stop_mode : mode_now;
    wire next_stopped = (next_state == ST_STOP);
    wire next_hf = ~next_stopped & (osc_mode != MODE_SLOW); // RULE_04 RULE_05 RULE_06
    wire next_lf = ~next_stopped & (osc_mode != MODE_SINGLE); // RULE_04 RULE_05 RULE_06
    wire next_halted = next_state != ST_RUN;
    wire next_clk_off = next_stopped | (next_state == ST_WARMUP);
    wire next_periph_off = next_clk_off | (next_state == ST_TB_HALT); // RULE_20
    wire halt_entry = (state == ST_RUN) & next_halted;
    wire next_vector = imf_i & (idle_release |
        (tb_release & tbt_irq_en & individual_interrupt_enable[TBT_LATCH_IDX]));

    // ********************************************************
    // state machine
    // ********************************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (stop_start) begin
                    next_state = ST_STOP;
                end else if (idle_req & ~idle_refused) begin
                    next_state = ST_IDLE;
                end else if (tg_req & ~wdt_int_i) begin
                    next_state = ST_TB_HALT;
                end
            end
            ST_STOP: begin
                if (stop_release) begin
                    next_state = ST_WARMUP; // RULE_01
                end
            end
            ST_WARMUP: begin
                if (wuc_done) begin
                    next_state = ST_RUN; // RULE_01
                end
            end
            ST_IDLE: begin
                if (wake_pending) begin
                    next_state = ST_RUN; // RULE_17 RULE_19
                end
            end
            ST_TB_HALT: begin
                if (tbt_fall) begin
                    next_state = ST_RUN; // RULE_25
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_WARMUP; // RULE_16
            stop_mode <= MODE_SINGLE; // RULE_16
        end else begin
            state <= next_state;
            if (stop_start && state == ST_RUN) begin
                stop_mode <= mode_now;
            end
        end
    end

    // ********************************************************
    // synchronisers
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rel_q <= 3'h0;
            rel_stable <= 1'b0;
            tb_q <= 3'h0;
            tb_stable <= 1'b0;
        end else begin
            rel_q <= {rel_q[1:0], stop_release_i};
            tb_q <= {tb_q[1:0], tbt_src_clk_i};
            if (rel_agree) begin
                rel_stable <= rel_q[2];
            end
            if (tb_agree) begin
                tb_stable <= tb_q[2];
            end
        end
    end

    // ********************************************************
    // warm-up counter
    // ********************************************************
    // counts only while warming up, so the load value times WUC_DIV sets the time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wuc_cnt <= WARMUP_RST;
            wuc_div <= 16'h0000;
        end else if (state != ST_WARMUP) begin
            wuc_cnt <= warmup_load; // RULE_02
            wuc_div <= 16'h0000;
        end else begin
            wuc_div <= wuc_tick ? 16'h0000 : wuc_div + 16'h0001;
            if (wuc_tick && !wuc_done) begin
                wuc_cnt <= wuc_cnt - 16'h0001;
            end
        end
    end

    // ********************************************************
    // software registers
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            system_control_first <= SYS_FIRST_RST;
            system_control_second <= SYS_SECOND_RST;
            warmup_load <= WARMUP_RST;
            individual_interrupt_enable <= '0;
            time_base_timer_control <= TBT_CTRL_RST;
        end else begin
            if (wr_b0 && sel_first) begin
                // the stop bit is a trigger, never kept set
                system_control_first <= wb_dat_i[7:0] & ~(8'h01 << FIRST_STOP_BIT);
            end
            if (wr_b0 && sel_second && state == ST_RUN) begin
                system_control_second <= wb_dat_i[7:0];
                system_control_second[SECOND_IDLE_BIT] <= next_state == ST_IDLE; // RULE_13
                system_control_second[SECOND_TIMING_GEN_HALT_REQUEST_BIT] <= next_state == ST_TB_HALT;
            end else if (idle_release) begin
                system_control_second[SECOND_IDLE_BIT] <= 1'b0; // RULE_15
            end else if (tb_release) begin
                system_control_second[SECOND_TIMING_GEN_HALT_REQUEST_BIT] <= 1'b0; // RULE_15
            end
            if (wr_b0 && sel_warmup) begin
                warmup_load[7:0] <= wb_dat_i[7:0];
            end
            if (wr_b1 && sel_warmup) begin
                warmup_load[15:8] <= wb_dat_i[15:8];
            end
            if (wr_b0 && sel_int_en) begin
                individual_interrupt_enable <= wb_dat_i[NUM_INT-1:0];
            end
            if (wr_b0 && sel_tbt) begin
                time_base_timer_control <= wb_dat_i[7:0];
            end
        end
    end

    // ********************************************************
    // interrupt latches
    // ********************************************************
    // set beats a software clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INT; gi++) begin : g_latch
            wire tb_set = (gi == TBT_LATCH_IDX) & tb_release & tbt_irq_en;
            wire clr = wr_b0 & sel_latch & ~wb_dat_i[gi]; // RULE_18
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    interrupt_latch[gi] <= 1'b0;
                end else if (int_req_i[gi] || tb_set) begin
                    interrupt_latch[gi] <= 1'b1;
                end else if (clr) begin
                    interrupt_latch[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ********************************************************
    // outputs
    // ********************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= READ_ZERO;
            cpu_halt_o <= 1'b1;
            wdt_halt_o <= 1'b1;
            periph_clk_en_o <= 1'b0;
            tbt_clk_en_o <= 1'b0;
            retain_o <= 1'b1;
            hf_osc_en_o <= 1'b1;
            lf_osc_en_o <= 1'b0;
            wuc_src_hf_o <= 1'b1;
            prescaler_clr_o <= 1'b0;
            resume_o <= 1'b0;
            vector_req_o <= 1'b0;
            pc_hold_o <= '0;
            interrupt_latch_o <= '0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req && !wb_ack_o) begin
                wb_dat_o <= read_data;
            end
            cpu_halt_o <= next_halted; // RULE_01 RULE_08
            wdt_halt_o <= next_halted; // RULE_08
            periph_clk_en_o <= ~next_periph_off; // RULE_08 RULE_20
            tbt_clk_en_o <= ~next_clk_off; // RULE_20
            retain_o <= next_halted; // RULE_09 RULE_21
            hf_osc_en_o <= next_hf;
            lf_osc_en_o <= next_lf;
            wuc_src_hf_o <= stop_mode != MODE_SLOW; // RULE_07
            prescaler_clr_o <= (state == ST_WARMUP) & wuc_done; // RULE_03
            resume_o <= (state != ST_RUN) & (next_state == ST_RUN);
            vector_req_o <= next_vector; // RULE_19
            if (halt_entry) begin
                pc_hold_o <= next_pc_i; // RULE_10 RULE_22
            end
            interrupt_latch_o <= interrupt_latch;
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_stop_osc_off;
        (state == ST_STOP) && ($past(state) == ST_STOP) |-> !hf_osc_en_o && !lf_osc_en_o;
    endproperty
    a_stop_osc_off: assert property (p_stop_osc_off) // RULE_01
        else $error("oscillator running in stop");

    property p_warmup_halted;
        (state == ST_WARMUP) && ($past(state) == ST_WARMUP) |-> cpu_halt_o && !periph_clk_en_o;
    endproperty
    a_warmup_halted: assert property (p_warmup_halted) // RULE_01
        else $error("activity during warm-up");

    property p_resume_clear;
        (state == ST_WARMUP) && wuc_done |=> prescaler_clr_o && resume_o && (state == ST_RUN);
    endproperty
    a_resume_clear: assert property (p_resume_clear) // RULE_03
        else $error("no prescaler clear at resume");

    property p_single_osc;
        (state == ST_WARMUP) && (stop_mode == MODE_SINGLE) ##1 (state == ST_WARMUP)
            |-> hf_osc_en_o && !lf_osc_en_o;
    endproperty
    a_single_osc: assert property (p_single_osc) // RULE_04
        else $error("wrong oscillators after single-clock stop");

    property p_dual_osc;
        (state == ST_WARMUP) && (stop_mode == MODE_DUAL) ##1 (state == ST_WARMUP)
            |-> hf_osc_en_o && lf_osc_en_o && wuc_src_hf_o;
    endproperty
    a_dual_osc: assert property (p_dual_osc) // RULE_05 RULE_07
        else $error("wrong oscillators after dual-clock stop");

    property p_slow_osc;
        (state == ST_WARMUP) && (stop_mode == MODE_SLOW) ##1 (state == ST_WARMUP)
            |-> !hf_osc_en_o && lf_osc_en_o;
    endproperty
    a_slow_osc: assert property (p_slow_osc) // RULE_06
        else $error("wrong oscillators after slow stop");

    property p_idle_refused;
        (state == ST_RUN) && idle_req && idle_refused && !stop_start |=>
            (state == ST_RUN) && !system_control_second[SECOND_IDLE_BIT];
    endproperty
    a_idle_refused: assert property (p_idle_refused) // RULE_13 RULE_14
        else $error("halt entered with release pending");

    property p_idle_release;
        idle_release |=> (state == ST_RUN) && !system_control_second[SECOND_IDLE_BIT]
            && (vector_req_o == $past(imf_i));
    endproperty
    a_idle_release: assert property (p_idle_release) // RULE_15 RULE_17 RULE_19
        else $error("bad release from cpu halt");

    property p_pc_held;
        (state != ST_RUN) && ($past(state) != ST_RUN) |-> $stable(pc_hold_o) && wdt_halt_o;
    endproperty
    a_pc_held: assert property (p_pc_held) // RULE_08 RULE_10 RULE_22
        else $error("pc hold changed while halted");

    property p_tb_gate;
        (state == ST_TB_HALT) && ($past(state) == ST_TB_HALT) |->
            !periph_clk_en_o && tbt_clk_en_o;
    endproperty
    a_tb_gate: assert property (p_tb_gate) // RULE_20
        else $error("clock gating wrong in time-base halt");

endmodule

// ---- verification/lpmc_cpu_model.sv ----
// cpu core and interrupt controller stand-in facing the low power controller
`timescale 1ns/1ps
module lpmc_cpu_model (
    // clock, reset and bench commands
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bus_busy_i,
    input wire logic imf_cmd_i,
    input wire logic wdt_cmd_i,
    input wire logic [7:0] req_cmd_i,
    // controller side
    input wire logic cpu_halt_i,
    output logic imf_o,
    output logic wdt_int_o,
    output logic [7:0] int_req_o,
    output logic [15:0] next_pc_o
);
    logic busy_q;
    assign imf_o = imf_cmd_i;
    assign wdt_int_o = wdt_cmd_i;
    assign int_req_o = req_cmd_i;
    // store still in flight: pc must not run past the halting instruction
    always_ff @(posedge clk_i) begin
        busy_q <= bus_busy_i;
        if (rst_i)
            next_pc_o <= 16'h0002;
        else if (!(bus_busy_i || busy_q || cpu_halt_i))
            next_pc_o <= next_pc_o + 16'h0002;
    end
endmodule

// ---- verification/low_power_mode_controller_bench.sv ----
// self-checking bench of the low power mode controller
`timescale 1ns/1ps
module low_power_mode_controller_bench;
    import lpmc_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, imf_i, wdt_int_i;
    logic stop_release_i, tbt_src_clk_i, cpu_halt_o, wdt_halt_o, periph_clk_en_o;
    logic tbt_clk_en_o, retain_o, hf_osc_en_o, lf_osc_en_o, wuc_src_hf_o;
    logic prescaler_clr_o, resume_o, vector_req_o, imf_cmd, wdt_cmd;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [7:0] wb_adr_i, int_req_i, interrupt_latch_o, req_cmd;
    logic [3:0] wb_sel_i;
    logic [15:0] next_pc_i, pc_hold_o;
    int error_cnt, n_checks, cyc_cnt, n;
    lpmc_top u_lpmc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .imf_i(imf_i),
        .wdt_int_i(wdt_int_i), .int_req_i(int_req_i), .next_pc_i(next_pc_i),
        .stop_release_i(stop_release_i), .tbt_src_clk_i(tbt_src_clk_i),
        .cpu_halt_o(cpu_halt_o), .wdt_halt_o(wdt_halt_o), .periph_clk_en_o(periph_clk_en_o),
        .tbt_clk_en_o(tbt_clk_en_o), .retain_o(retain_o), .hf_osc_en_o(hf_osc_en_o),
        .lf_osc_en_o(lf_osc_en_o), .wuc_src_hf_o(wuc_src_hf_o),
        .prescaler_clr_o(prescaler_clr_o), .resume_o(resume_o),
        .vector_req_o(vector_req_o), .pc_hold_o(pc_hold_o),
        .interrupt_latch_o(interrupt_latch_o));
    lpmc_cpu_model u_lpmc_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .bus_busy_i(wb_cyc_i),
        .imf_cmd_i(imf_cmd), .wdt_cmd_i(wdt_cmd), .req_cmd_i(req_cmd),
        .cpu_halt_i(cpu_halt_o), .imf_o(imf_i), .wdt_int_o(wdt_int_i),
        .int_req_o(int_req_i), .next_pc_o(next_pc_i));
    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // request stands until ack is sampled high at a rising edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h3;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wait_resume;
        do @(negedge clk_i); while (resume_o !== 1'b1);
    endtask
    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_reset;
        @(negedge clk_i);
        chk({cpu_halt_o, periph_clk_en_o, hf_osc_en_o}, 32'h5);
        wait_resume();
        chk(prescaler_clr_o, 32'h1);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_idle(input logic interrupt_master_enable);
        imf_cmd <= interrupt_master_enable;
        wb(1'b1, ADR_INT_EN, 32'h1);
        wb(1'b1, ADR_SYS_SECOND, 32'h8);
        repeat (2) @(negedge clk_i);
        chk({cpu_halt_o, wdt_halt_o, periph_clk_en_o, retain_o}, 32'hF);
        chk(pc_hold_o, next_pc_i);
        @(posedge clk_i);
        req_cmd <= 8'h01;
        wait_resume();
        chk(vector_req_o, interrupt_master_enable);
        @(posedge clk_i);
        req_cmd <= 8'h00;
        wb(1'b0, ADR_SYS_SECOND, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, ADR_INT_LATCH, 32'h0);
        imf_cmd <= 1'b0;
    endtask
    task automatic t_refuse;
        req_cmd <= 8'h01;
        wb(1'b1, ADR_SYS_SECOND, 32'h8);
        repeat (3) @(negedge clk_i);
        chk(cpu_halt_o, 32'h0);
        wb(1'b0, ADR_SYS_SECOND, 32'h0);
        chk(rd, 32'h0);
        req_cmd <= 8'h00;
        wb(1'b1, ADR_INT_LATCH, 32'h0);
        wdt_cmd <= 1'b1;
        wb(1'b1, ADR_SYS_SECOND, 32'h8);
        repeat (3) @(negedge clk_i);
        chk(cpu_halt_o, 32'h0);
        @(posedge clk_i);
        wdt_cmd <= 1'b0;
    endtask
    task automatic t_tb_halt;
        wb(1'b1, ADR_TBT_CTRL, 32'h80);
        wb(1'b1, ADR_SYS_SECOND, 32'h4);
        repeat (2) @(negedge clk_i);
        chk({cpu_halt_o, periph_clk_en_o, tbt_clk_en_o, retain_o}, 32'hB);
        chk(pc_hold_o, next_pc_i);
        @(posedge clk_i);
        tbt_src_clk_i <= 1'b0;
        wait_resume();
        repeat (2) @(negedge clk_i);
        chk(interrupt_latch_o[TBT_LATCH_IDX], 32'h1);
        @(posedge clk_i);
        tbt_src_clk_i <= 1'b1;
        wb(1'b1, ADR_INT_LATCH, 32'h0);
        wb(1'b1, ADR_TBT_CTRL, 32'h0);
    endtask
    // level release: a high pin refuses the stop, later releases it
    task automatic t_level;
        wb(1'b1, ADR_WARMUP, 32'h2);
        wb(1'b1, ADR_SYS_FIRST, 32'h40);
        stop_release_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wb(1'b1, ADR_SYS_FIRST, 32'hC0);
        repeat (2) @(negedge clk_i);
        chk(cpu_halt_o, 32'h0);
        @(posedge clk_i);
        stop_release_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        wb(1'b1, ADR_SYS_FIRST, 32'hC0);
        repeat (2) @(negedge clk_i);
        chk(cpu_halt_o, 32'h1);
        @(posedge clk_i);
        stop_release_i <= 1'b1;
        wait_resume();
        chk(prescaler_clr_o, 32'h1);
        wb(1'b1, ADR_SYS_FIRST, 32'h00);
        stop_release_i <= 1'b0;
    endtask
    // exp packs high oscillator, low oscillator and warm-up source
    task automatic t_stop(input logic [31:0] mode, input logic [31:0] exp);
        wb(1'b1, ADR_WARMUP, 32'h2);
        wb(1'b1, ADR_SYS_SECOND, mode);
        wb(1'b1, ADR_SYS_FIRST, 32'h80);
        repeat (2) @(negedge clk_i);
        chk({cpu_halt_o, hf_osc_en_o, lf_osc_en_o}, 32'h4);
        @(posedge clk_i);
        stop_release_i <= 1'b1;
        do @(negedge clk_i); while (!(hf_osc_en_o | lf_osc_en_o));
        chk({hf_osc_en_o, lf_osc_en_o, wuc_src_hf_o}, exp);
        chk({cpu_halt_o, periph_clk_en_o}, 32'h2);
        n = 0;
        while (resume_o !== 1'b1) begin
            @(negedge clk_i);
            n++;
        end
        chk(n >= 32 && n <= 60, 32'h1);
        chk(prescaler_clr_o, 32'h1);
        @(posedge clk_i);
        stop_release_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, imf_cmd, wdt_cmd, stop_release_i} = 6'h0;
        {wb_adr_i, wb_dat_i, req_cmd, error_cnt, n_checks, cyc_cnt} = '0;
        wb_sel_i = 4'h3;
        tbt_src_clk_i = 1'b1;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_idle(1'b0);
        t_idle(1'b1);
        t_refuse();
        t_tb_halt();
        t_level();
        t_stop(32'h00, 32'h5);
        t_stop(32'h20, 32'h7);
        t_stop(32'h30, 32'h2);
        give_verdict();
    end
endmodule
